/* File: ipv_pkg.sv */
// package for the interrupt priority and vectoring block
// assumes an AHB-Lite slave port and one core clock hclk
package ipv_pkg;
    // source count and level width
    localparam int NSRC = 18;
    localparam int LVLW = 2;
    localparam int NLVL = 4;
    // register indices, byte address is index * 4
    localparam logic [7:0] IDX_PRIO_HI_A = 8'hB7;
    localparam logic [7:0] IDX_PRIO_LO_A = 8'hB8;
    localparam logic [7:0] IDX_PRIO_LO_B = 8'hEF;
    localparam logic [7:0] IDX_PRIO_HI_B = 8'hF7;
    localparam logic [7:0] IDX_PRIO_LO_C = 8'hFE;
    localparam logic [7:0] IDX_PRIO_HI_C = 8'hFF;
    localparam logic [7:0] IDX_STATUS    = 8'h80;
    // priority register slots inside the block
    localparam int NREG = 6;
    localparam int SLOT_HI_A = 0;
    localparam int SLOT_LO_A = 1;
    localparam int SLOT_LO_B = 2;
    localparam int SLOT_HI_B = 3;
    localparam int SLOT_LO_C = 4;
    localparam int SLOT_HI_C = 5;
    // writable bit masks, reserved bits read zero
    localparam logic [7:0] MASK_A = 8'h7F;
    localparam logic [7:0] MASK_B = 8'hFF;
    localparam logic [7:0] MASK_C = 8'h07;
    localparam logic [7:0] PRIO_RST = 8'h00;
    // status word field positions
    localparam int ST_INSV_LSB = 0;
    localparam int ST_LVL_LSB  = 4;
    localparam int ST_BUSY_BIT = 6;
    localparam int ST_SRC_LSB  = 8;
    // length of the hardware long call in cycles
    localparam int CALL_CYCLES_DEF = 4;
    // sources whose flag drops when their call is taken
    localparam logic [NSRC-1:0] CLR_MASK_DEF = 18'h10149;
    // vector address per source, natural order 0 highest
    localparam logic [15:0] VEC_TAB [NSRC] = '{
        16'h0003, 16'h0043, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
        16'h0013, 16'h003B, 16'h001B, 16'h0023, 16'h0073, 16'h004B,
        16'h002B, 16'h0063, 16'h006B, 16'h007B, 16'h0083, 16'h008B};
    // one taken call as seen by the core
    typedef struct packed {
        logic [15:0]     vec;
        logic [4:0]      src;
        logic [LVLW-1:0] lvl;
    } ipv_call_t;
    // call sequencer states
    typedef enum logic {ST_IDLE = 1'b0, ST_CALL = 1'b1} ipv_state_t;
endpackage

/* File: ipv_ctrl.sv */
// interrupt priority, arbitration and service tracking
// assumes the core sequencer on hclk gives gated flags and
// instruction status, and software uses word AHB-Lite access
// Summary of operation
// - bank a high bits for seven sources
// - level is high bit over low bit
// - bank b low bits, eight sources
// - bank b high bits, eight sources
// - bank c low bits, three sources, page 0
// - bank c high bits, three sources, page 0
// - all priority registers reset to zero
// - flags sampled, resolved every cycle
// - no call while equal/higher level serviced
// - call only on last instruction cycle
// - no call on config write or interrupt return
// - blocked requests are never remembered
// - call pushes pc, not status word
// - pc gets winning source vector
// - flag clear on call is per source
// - interrupt return ends current service
// - popped return address is not checked
// - plain return leaves service state set
// - highest level wins, then natural order
// - hardware call lasts four cycles
`timescale 1ns/100ps
`default_nettype none
module ipv_ctrl
    import ipv_pkg::*;
#(
    parameter int               CALL_CYCLES = CALL_CYCLES_DEF,
    parameter logic [NSRC-1:0]  CLR_MASK    = CLR_MASK_DEF
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic [NSRC-1:0]  irq_req,
    input  wire logic             instr_last,
    input  wire logic             instr_cfg_wr,
    input  wire logic             instr_irq_ret,
    input  wire logic             irq_ret_done,
    output logic                  call_req,
    output ipv_call_t             call_info,
    output logic [NSRC-1:0]       flag_clr,
    output logic                  call_busy,
    output logic [NLVL-1:0]       in_service
);

    // refuse shapes the logic cannot serve
    if (CALL_CYCLES < 1 || CALL_CYCLES > 15) begin : g_chk
        $error("ipv_ctrl: CALL_CYCLES out of range");
    end

    // bus side state
    logic             wr_pend_q;   // write data phase due
    logic [7:0]       wr_idx_q;    // index of that write
    logic [31:0]      rdata_q;     // read data for data phase
    logic [7:0]       prio_q [NREG]; // priority registers
    logic [7:0]       prio_d [NREG]; // with pending write applied
    logic [7:0]       wr_mask [NREG]; // writable bits per slot

    // sequencer and service state
    ipv_state_t       state_q;     // call sequencer
    logic [3:0]       cyc_q;       // cycles left in the call
    logic [NLVL-1:0]  insv_q;      // in-service per level
    logic [NLVL-1:0]  insv_d;
    logic             call_q;      // one-cycle call pulse
    ipv_call_t        info_q;      // last taken call
    logic [NSRC-1:0]  clr_q;       // flag clear pulses

    // arbitration results
    logic [NSRC-1:0]  src_hi;
    logic [NSRC-1:0]  src_lo;
    logic             win_vld;
    logic [4:0]       win_src;
    logic [LVLW-1:0]  win_lvl;
    logic             blocked;
    logic             take;
    logic [NLVL-1:0]  lvl_seen;    // levels among live requests

    // address phase qualifier
    logic             ap_valid;
    logic [7:0]       ap_idx;
    logic             ap_word;

    assign ap_valid = hsel && htrans[1] && hready;
    assign ap_word  = (hsize == 3'h2) && (haddr[31:10] == 22'h0);
    assign ap_idx   = haddr[9:2];

    // writable masks, reserved bits stay zero
    assign wr_mask[SLOT_HI_A] = MASK_A;
    assign wr_mask[SLOT_LO_A] = MASK_A;
    assign wr_mask[SLOT_LO_B] = MASK_B;
    assign wr_mask[SLOT_HI_B] = MASK_B;
    assign wr_mask[SLOT_LO_C] = MASK_C;
    assign wr_mask[SLOT_HI_C] = MASK_C;

    // index to slot, -1 for no priority register
    function automatic int slot_of(input logic [7:0] idx);
        int s;
        s = -1;
        unique case (idx)
            IDX_PRIO_HI_A: s = SLOT_HI_A;
            IDX_PRIO_LO_A: s = SLOT_LO_A;
            IDX_PRIO_LO_B: s = SLOT_LO_B;
            IDX_PRIO_HI_B: s = SLOT_HI_B;
            IDX_PRIO_LO_C: s = SLOT_LO_C;
            IDX_PRIO_HI_C: s = SLOT_HI_C;
            default:       s = -1;
        endcase
        return s;
    endfunction

    // register values after this cycle's write; read mux uses
    // them so a read right behind a write sees the new value
    always_comb begin
        int s;
        s = slot_of(wr_idx_q);
        for (int i = 0; i < NREG; i++) begin
            prio_d[i] = prio_q[i];
        end
        if (wr_pend_q && s >= 0) begin
            prio_d[s] = hwdata[7:0] & wr_mask[s];
        end
    end

    // bus write tracking, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end else begin
            wr_pend_q <= ap_valid && hwrite && ap_word;
            if (ap_valid) begin
                wr_idx_q <= ap_idx;
            end
        end
    end

    // priority registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NREG; i++) begin
                prio_q[i] <= PRIO_RST;
            end
        end else begin
            for (int i = 0; i < NREG; i++) begin
                prio_q[i] <= prio_d[i];
            end
        end
    end

    // read data latched in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0;
        end else if (ap_valid && !hwrite) begin
            if (!ap_word) begin
                rdata_q <= 32'h0;
            end else if (ap_idx == IDX_STATUS) begin
                // status shows service state and last call
                rdata_q <= {19'h0, info_q.src, 1'b0,
                            call_busy, info_q.lvl, insv_q};
            end else if (slot_of(ap_idx) >= 0) begin
                rdata_q <= {24'h0, prio_d[slot_of(ap_idx)]};
            end else begin
                // unmapped reads answer zero
                rdata_q <= 32'h0;
            end
        end
    end

    // response is always ready and OKAY
    // no wait states: every register answers from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
    assign hrdata = rdata_q;

    // per source high and low bits in natural order
    assign src_hi = {prio_q[SLOT_HI_C][2], prio_q[SLOT_HI_C][1],
                     prio_q[SLOT_HI_C][0], prio_q[SLOT_HI_B][3],
                     prio_q[SLOT_HI_B][2], prio_q[SLOT_HI_B][7],
                     prio_q[SLOT_HI_B][6], prio_q[SLOT_HI_B][5],
                     prio_q[SLOT_HI_A][4], prio_q[SLOT_HI_A][3],
                     prio_q[SLOT_HI_B][1], prio_q[SLOT_HI_A][2],
                     prio_q[SLOT_HI_A][6], prio_q[SLOT_HI_B][0],
                     prio_q[SLOT_HI_A][1], prio_q[SLOT_HI_B][4],
                     prio_q[SLOT_HI_A][5], prio_q[SLOT_HI_A][0]};
    assign src_lo = {prio_q[SLOT_LO_C][2], prio_q[SLOT_LO_C][1],
                     prio_q[SLOT_LO_C][0], prio_q[SLOT_LO_B][3],
                     prio_q[SLOT_LO_B][2], prio_q[SLOT_LO_B][7],
                     prio_q[SLOT_LO_B][6], prio_q[SLOT_LO_B][5],
                     prio_q[SLOT_LO_A][4], prio_q[SLOT_LO_A][3],
                     prio_q[SLOT_LO_B][1], prio_q[SLOT_LO_A][2],
                     prio_q[SLOT_LO_A][6], prio_q[SLOT_LO_B][0],
                     prio_q[SLOT_LO_A][1], prio_q[SLOT_LO_B][4],
                     prio_q[SLOT_LO_A][5], prio_q[SLOT_LO_A][0]};

    // resolve the winner in the cycle the flags are seen; no
    // request is held, so a flag gone by now is simply lost
    always_comb begin
        logic [LVLW-1:0] l;
        l       = '0;
        win_vld = 1'b0;
        win_src = 5'h0;
        win_lvl = '0;
        // walk from lowest natural priority so ties go upward
        for (int i = NSRC - 1; i >= 0; i--) begin
            l = {src_hi[i], src_lo[i]};
            if (irq_req[i] && (!win_vld || l >= win_lvl)) begin
                win_vld = 1'b1;
                win_src = 5'(i);
                win_lvl = l;
            end
        end
    end

    // levels present among live requests; kept apart from the
    // arbiter walk so a broken walk cannot vouch for itself
    always_comb begin
        lvl_seen = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (irq_req[i]) begin
                lvl_seen[{src_hi[i], src_lo[i]}] = 1'b1;
            end
        end
    end

    // any level at or above the winner still in service
    // the shift drops the levels below the winner; what is left blocks
    assign blocked = |(insv_q >> win_lvl);

    // call conditions, evaluated fresh every cycle; nothing here
    // is registered, so a refused request leaves no trace
    assign take = win_vld && !blocked && instr_last
                  && !instr_cfg_wr && !instr_irq_ret
                  && (state_q == ST_IDLE);

    // call sequencer, busy for the call's length
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            cyc_q   <= 4'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: if (take) begin
                    state_q <= ST_CALL;
                    cyc_q   <= 4'(CALL_CYCLES - 1);
                end
                ST_CALL: if (cyc_q == 4'h0) begin
                    state_q <= ST_IDLE;
                end else begin
                    cyc_q <= cyc_q - 4'h1;
                end
            endcase
        end
    end

    // call pulse with vector; the core pushes pc only, the
    // status word is left alone as for a software long call
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            call_q <= 1'b0;
            info_q <= '0;
            clr_q  <= '0;
        end else begin
            call_q <= take;
            clr_q  <= '0;
            if (take) begin
                info_q.vec <= VEC_TAB[win_src];
                info_q.src <= win_src;
                info_q.lvl <= win_lvl;
                // only some sources drop their flag on entry
                clr_q <= CLR_MASK & (NSRC'(1) << win_src);
            end
        end
    end

    // in-service: return clears the top level, a new call sets
    // its level; the set is applied last so it always wins
    always_comb begin
        insv_d = insv_q;
        if (irq_ret_done) begin
            // the return address itself is never inspected
            for (int i = 0; i < NLVL; i++) begin
                if (insv_q[i] && ((insv_q >> i) == 4'h1)) begin
                    insv_d[i] = 1'b0;
                end
            end
        end
        if (take) begin
            insv_d[win_lvl] = 1'b1;
        end
    end

    // a plain return has no input here, so service stays set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            insv_q <= '0;
        end else begin
            insv_q <= insv_d;
        end
    end

    // outputs come straight from their registers
    assign call_req   = call_q;
    assign call_info  = info_q;
    assign flag_clr   = clr_q;
    assign call_busy  = (state_q == ST_CALL);
    assign in_service = insv_q;

    // checks on what this block drives
    AST_CALL_LAST: assert property (@(posedge hclk) disable iff (!hresetn)
        call_q |-> $past(instr_last))
        else $error("call without last instruction cycle");

    AST_CALL_NOBLOCK: assert property (@(posedge hclk) disable iff (!hresetn)
        call_q |-> !$past(instr_cfg_wr) && !$past(instr_irq_ret))
        else $error("call during config write or return");

    AST_BUSY_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
        call_q |-> call_busy [*4] ##1 !call_busy)
        else $error("call length wrong");

    AST_VECTOR: assert property (@(posedge hclk) disable iff (!hresetn)
        call_q |-> info_q.vec == VEC_TAB[info_q.src])
        else $error("vector does not match source");

    AST_NEST: assert property (@(posedge hclk) disable iff (!hresetn)
        call_q |-> (($past(insv_q) >> info_q.lvl) == 4'h0))
        else $error("call over equal or higher service");

    // level index taken at the call, not one cycle back
    AST_SET_LVL: assert property (@(posedge hclk) disable iff (!hresetn)
        call_q |-> insv_q[info_q.lvl]
            && ((($past(insv_q) >> info_q.lvl) & 4'h1) == 4'h0))
        else $error("service level not recorded");

    AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        (!call_q && !$past(irq_ret_done)) |-> insv_q == $past(insv_q))
        else $error("service state moved without cause");

    AST_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        call_q |-> flag_clr == (CLR_MASK & (NSRC'(1) << info_q.src)))
        else $error("flag clear does not follow source");

    // source index taken at the call, the flags one cycle back
    AST_LIVE_REQ: assert property (@(posedge hclk) disable iff (!hresetn)
        call_q |-> |($past(irq_req) & (NSRC'(1) << info_q.src)))
        else $error("call for a request not active");

    // no live request may sit above the winner's level
    AST_WINNER: assert property (@(posedge hclk) disable iff (!hresetn)
        take |-> ((lvl_seen >> win_lvl) == 4'h1))
        else $error("winner level below a live request");

endmodule // ipv_ctrl
`default_nettype wire

/* File: ipv_core_model.sv */
// core sequencer model: instruction timing, return stack, returns
// assumes ipv_ctrl on the same hclk and hresetn, bench drives commands
`timescale 1ns/100ps
`default_nettype none
module ipv_core_model
    import ipv_pkg::*;
(
    input  wire logic      hclk,
    input  wire logic      hresetn,
    input  wire logic      slow,         // three-cycle instructions
    input  wire logic      cfg_cmd,      // instruction writes enable/priority
    input  wire logic      irq_ret_cmd,  // instruction is interrupt return
    input  wire logic      ret_cmd,      // instruction is plain return
    input  wire logic      call_req,
    input  wire ipv_call_t call_info,
    input  wire logic      call_busy,
    output logic           instr_last,
    output logic           instr_cfg_wr,
    output logic           instr_irq_ret,
    output logic           irq_ret_done,
    output logic [15:0]    pc_q
);
    logic [1:0]  cnt_q;      // cycle within instruction
    logic [15:0] stk_q [8];  // return stack, shallow on purpose
    logic [2:0]  sp_q;       // stack depth

    // last cycle flag, low while the hardware call runs
    assign instr_last   = !call_busy && (cnt_q >= (slow ? 2'h2 : 2'h0));
    assign instr_cfg_wr = cfg_cmd;
    assign instr_irq_ret = irq_ret_cmd;

    // instruction cycle counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 2'h0;
        end else if (call_busy || instr_last) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    // pc and stack: call pushes pc only, returns pop without any check
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_q         <= 16'h0000;
            sp_q         <= 3'h0;
            irq_ret_done <= 1'b0;
        end else begin
            irq_ret_done <= 1'b0;
            if (call_req) begin
                stk_q[sp_q] <= pc_q;
                sp_q        <= sp_q + 3'h1;
                pc_q        <= call_info.vec;
            end else if (instr_last && (irq_ret_cmd || ret_cmd)) begin
                pc_q         <= stk_q[sp_q - 3'h1];
                sp_q         <= sp_q - 3'h1;
                irq_ret_done <= irq_ret_cmd;
            end else if (instr_last) begin
                pc_q <= pc_q + 16'h0001;
            end
        end
    end
endmodule // ipv_core_model
`default_nettype wire

/* File: ipv_ctrl_tb_top.sv */
// self-checking bench for ipv_ctrl with the core model beside it
// assumes single 100 MHz clock and word-only AHB-Lite traffic
`timescale 1ns/100ps
`default_nettype none
module ipv_ctrl_tb_top
    import ipv_pkg::*;
;
    logic            hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    logic [31:0]     haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]      htrans = 2'h0;
    logic [NSRC-1:0] irq_req = '0;
    logic            slow = 1'b0, cfg_cmd = 1'b0, irq_ret_cmd = 1'b0, ret_cmd = 1'b0;
    logic [31:0]     hrdata, rd;
    logic            hreadyout, hresp, call_req, call_busy, ok_q;
    logic [NSRC-1:0] flag_clr;
    logic [NLVL-1:0] in_service;
    ipv_call_t       call_info;
    logic            instr_last, instr_cfg_wr, instr_irq_ret, irq_ret_done;
    int              err_count = 0, checks = 0, cyc = 0;
    logic [7:0]      hi [3], lo [3];  // register images
    // source to bank and bit of its priority pair
    localparam int BANK [NSRC] = '{0,0,1,0,1,0,0,1,0,0,1,1,1,1,1,2,2,2};
    localparam int BITP [NSRC] = '{0,5,4,1,0,6,2,1,3,4,5,6,7,2,3,0,1,2};
    localparam logic [7:0] HI_IX [3] = '{IDX_PRIO_HI_A, IDX_PRIO_HI_B, IDX_PRIO_HI_C};
    localparam logic [7:0] LO_IX [3] = '{IDX_PRIO_LO_A, IDX_PRIO_LO_B, IDX_PRIO_LO_C};
    localparam logic [7:0] MSK [3]   = '{MASK_A, MASK_B, MASK_C};

    ipv_ctrl i_ipv_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq_req(irq_req), .instr_last(instr_last), .instr_cfg_wr(instr_cfg_wr),
        .instr_irq_ret(instr_irq_ret), .irq_ret_done(irq_ret_done), .call_req(call_req),
        .call_info(call_info), .flag_clr(flag_clr), .call_busy(call_busy),
        .in_service(in_service));
    ipv_core_model i_ipv_core_model (.hclk(hclk), .hresetn(hresetn), .slow(slow),
        .cfg_cmd(cfg_cmd), .irq_ret_cmd(irq_ret_cmd), .ret_cmd(ret_cmd), .call_req(call_req),
        .call_info(call_info), .call_busy(call_busy), .instr_last(instr_last),
        .instr_cfg_wr(instr_cfg_wr), .instr_irq_ret(instr_irq_ret),
        .irq_ret_done(irq_ret_done),
        .pc_q());

    // clock
    initial begin
        forever #5 hclk = ~hclk;
    end

    // cycle ceiling and cause of every call
    always @(posedge hclk) begin
        cyc  <= cyc + 1;
        ok_q <= instr_last && !instr_cfg_wr && !instr_irq_ret && !call_busy;
        if (call_req === 1'b1) chk(ok_q, 1'b1);
        if (cyc == 5000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask

    // one single word transfer, waits on hready in both phases
    task automatic bus(input logic wr, input logic [7:0] ix, input logic [31:0] wd);
        haddr  <= {22'h0, ix, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask

    // write images, reserved bits get random junk
    task automatic put(input bit rnd);
        logic [31:0] w;
        for (int b = 0; b < 3; b++) begin
            if (rnd) hi[b] = 8'($urandom) & MSK[b];
            if (rnd) lo[b] = 8'($urandom) & MSK[b];
            w = $urandom;
            bus(1'b1, HI_IX[b], {w[31:8], (w[7:0] & ~MSK[b]) | hi[b]});
            w = $urandom;
            bus(1'b1, LO_IX[b], {w[31:8], (w[7:0] & ~MSK[b]) | lo[b]});
        end
    endtask

    function automatic logic [1:0] lvl_of(input int s);
        return {hi[BANK[s]][BITP[s]], lo[BANK[s]][BITP[s]]};
    endfunction

    // expected winner: highest level, then lowest natural index
    function automatic int win(input logic [NSRC-1:0] r);
        int w = -1;
        for (int s = 0; s < NSRC; s++)
            if (r[s] && (w < 0 || lvl_of(s) > lvl_of(w))) w = s;
        return w;
    endfunction

    // wait for the call, check its content and its length
    task automatic take(input int s, input logic [3:0] base, input bit exact);
        int n = 0;
        while (call_req !== 1'b1 && n < 8) begin
            @(posedge hclk);
            n++;
        end
        if (exact) chk(n, 2);
        chk(call_req, 1'b1);
        chk(call_info, {VEC_TAB[s], 5'(s), lvl_of(s)});
        chk(flag_clr, CLR_MASK_DEF & (18'h1 << s));
        chk(in_service, base | (4'h1 << lvl_of(s)));
        n = 0;
        while (call_busy === 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        chk(n, 4);
    endtask

    task automatic ret(input bit intr, input logic [3:0] exp);
        if (intr) irq_ret_cmd <= 1'b1;
        else ret_cmd <= 1'b1;
        @(posedge hclk);
        irq_ret_cmd <= 1'b0;
        ret_cmd  <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(in_service, exp);
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge hclk);
            chk(call_req, 1'b0);
        end
    endtask

    task automatic results();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // main sequence
    initial begin
        logic [NSRC-1:0] r;
        void'($urandom(54));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values, then unmapped place
        for (int b = 0; b < 3; b++) begin
            bus(1'b0, HI_IX[b], 32'h0);
            chk(rd, 32'h0);
            bus(1'b0, LO_IX[b], 32'h0);
            chk(rd, 32'h0);
        end
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        // random levels and flags, readback then arbitration
        repeat (12) begin
            put(1'b1);
            for (int b = 0; b < 3; b++) begin
                bus(1'b0, HI_IX[b], 32'h0);
                chk(rd, {24'h0, hi[b]});
                bus(1'b0, LO_IX[b], 32'h0);
                chk(rd, {24'h0, lo[b]});
            end
            r = 18'($urandom | (32'h1 << ($urandom % NSRC)));
            irq_req <= r;
            take(win(r), 4'h0, 1'b1);
            irq_req <= '0;
            ret(1'b1, 4'h0);
        end
        // nesting: wake timer at level 3, all else level 0
        hi = '{default: 8'h00};
        lo = '{default: 8'h00};
        hi[2] = 8'h04;
        lo[2] = 8'h04;
        put(1'b0);
        irq_req <= 18'h00020;
        take(5, 4'h0, 1'b1);
        irq_req <= 18'h00001;
        quiet(6);
        irq_req <= 18'h20000;
        take(17, 4'h1, 1'b1);
        irq_req <= '0;
        bus(1'b0, IDX_STATUS, 32'h0);
        chk(rd, (32'h11 << ST_SRC_LSB) | (32'h3 << ST_LVL_LSB) | (32'h9 << ST_INSV_LSB));
        ret(1'b0, 4'h9);
        ret(1'b1, 4'h1);
        ret(1'b1, 4'h0);
        // config write blocks, blocked flag is forgotten
        cfg_cmd <= 1'b1;
        irq_req <= 18'h00008;
        quiet(4);
        cfg_cmd <= 1'b0;
        irq_req <= '0;
        quiet(6);
        // long instructions: call waits for the last cycle
        slow    <= 1'b1;
        irq_req <= 18'h00100;
        take(8, 4'h0, 1'b0);
        slow    <= 1'b0;
        irq_req <= '0;
        ret(1'b1, 4'h0);
        results();
    end
endmodule // ipv_ctrl_tb_top
`default_nettype wire
